// *** pkg/fault_route_map.svh ***
// Field widths, bit positions, reset values and codes of the fault router.
`ifndef FAULT_ROUTE_MAP_SVH
`define FAULT_ROUTE_MAP_SVH
`define DP_CAUSE_CODE 16'h009d
`define CAUSE_LOW_WIDTH 16
`define CAUSE_RST_VALUE 32'h0000_0000
`define ADDR_RST_VALUE 32'h0000_0000
`define CFG_HOST_CHECK_BIT 0
`define CFG_SYSERR_HOST_BIT 1
`endif

// *** pkg/fault_route_pkg.sv ***
// Types shared by the fault router modules.
package fault_route_pkg;
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_HOST,
    ROUTE_GUEST
  } route_t;
  typedef enum logic [1:0] {
    SE_CTX_SAVE,
    SE_FETCH,
    SE_CTX_RESTORE,
    SE_OTHER
  } sys_error_kind_t;
endpackage : fault_route_pkg

// *** pkg/route_if.sv ***
// Decision signals passed from the classifier to the recording logic.
`timescale 1ns/10ps
`default_nettype none
interface route_if;
  logic dp_host;
  logic se_valid;
  fault_route_pkg::route_t se_route;
  modport classifier (output dp_host, output se_valid, output se_route);
  modport recorder (input dp_host, input se_valid, input se_route);
endinterface : route_if
`default_nettype wire

// *** rtl/fault_classify.sv ***
// Combinational classifier deciding where guest faults are taken.
`timescale 1ns/10ps
`default_nettype none
module fault_classify (
  input wire logic guest_mode_in,
  input wire logic tbl_fault_in,
  input wire logic tbl_host_entry_in,
  input wire logic guest_irq_in,
  input wire logic host_check_in,
  input wire logic se_in,
  input wire fault_route_pkg::sys_error_kind_t se_kind_in,
  input wire logic se_to_host_in,
  route_if.classifier rt
);
  logic se_eligible;

  always_comb begin
    // Host-delivered table interrupt in guest mode, or guest table interrupt
    // hitting a host-managed entry while host checking is on.
    rt.dp_host = tbl_fault_in && guest_mode_in &&
      (!guest_irq_in || (tbl_host_entry_in && host_check_in));
  end

  always_comb begin
    se_eligible = (se_kind_in != fault_route_pkg::SE_OTHER);
    rt.se_valid = se_in && guest_mode_in && se_eligible;
    if (!rt.se_valid) begin
      rt.se_route = fault_route_pkg::ROUTE_NONE;
    end else if (se_to_host_in) begin
      rt.se_route = fault_route_pkg::ROUTE_HOST;
    end else begin
      rt.se_route = fault_route_pkg::ROUTE_GUEST;
    end
  end
endmodule : fault_classify
`default_nettype wire

// *** rtl/guest_fault_routing.sv ***
// Guest fault routing: decides host or guest handling and records status.
//
// Notes on behaviour
// - Table-read fault of a host table interrupt in guest mode goes to host.
// - Guest table interrupt on host entry, check bit set: goes to host.
// - That exception sets saved guest flag and cause low half to 009d.
// - The faulting table-read address is stored in the violation register.
// - Listed system error in guest mode, routing bit one: handled in host.
// - Listed system error in guest mode, routing bit zero: stays in guest.
`include "fault_route_map.svh"
`timescale 1ns/10ps
`default_nettype none
module guest_fault_routing #(
  parameter int ADDR_W = 32,
  parameter int CAUSE_W = 32
) (
  // Clock, reset and enable
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  // Core state and configuration
  input wire logic GUEST_MODE_IN,
  input wire logic [1:0] GUEST_CONFIG_IN,
  // Table read fault report
  input wire logic TBL_FAULT_IN,
  input wire logic TBL_GUEST_IRQ_IN,
  input wire logic TBL_HOST_ENTRY_IN,
  input wire logic [ADDR_W-1:0] TBL_ADDR_IN,
  // System error report
  input wire logic SE_IN,
  input wire logic [1:0] SE_KIND_IN,
  // Routing decisions
  output logic DP_HOST_OUT,
  output logic SE_HOST_OUT,
  output logic SE_GUEST_OUT,
  // Recorded state
  output logic GUEST_MODE_FLAG_OUT,
  output logic [CAUSE_W-1:0] CAUSE_OUT,
  output logic [ADDR_W-1:0] VIOL_ADDR_OUT
);
  // --------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------
  if (CAUSE_W < `CAUSE_LOW_WIDTH || ADDR_W < 1) begin : g_bad_width
    $error("guest_fault_routing: unsupported width");
  end

  // --------------------------------------------------------------
  // Configuration decode
  // --------------------------------------------------------------
  route_if rt ();
  logic host_entry_check_enable;
  logic sys_error_to_host;
  logic [CAUSE_W-1:0] cause_next;

  assign host_entry_check_enable = GUEST_CONFIG_IN[`CFG_HOST_CHECK_BIT];
  assign sys_error_to_host = GUEST_CONFIG_IN[`CFG_SYSERR_HOST_BIT];

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic se_kind_routed(input logic [1:0] kind);
    return fault_route_pkg::sys_error_kind_t'(kind) != fault_route_pkg::SE_OTHER;
  endfunction : se_kind_routed

  // --------------------------------------------------------------
  // Classifier
  // --------------------------------------------------------------
  fault_classify u_classify (
    .guest_mode_in(GUEST_MODE_IN),
    .tbl_fault_in(TBL_FAULT_IN),
    .tbl_host_entry_in(TBL_HOST_ENTRY_IN),
    .guest_irq_in(TBL_GUEST_IRQ_IN),
    .host_check_in(host_entry_check_enable),
    .se_in(SE_IN),
    .se_kind_in(fault_route_pkg::sys_error_kind_t'(SE_KIND_IN)),
    .se_to_host_in(sys_error_to_host),
    .rt(rt.classifier)
  );

  // --------------------------------------------------------------
  // Cause next value
  // --------------------------------------------------------------
  always_comb begin
    cause_next = CAUSE_OUT;
    cause_next[`CAUSE_LOW_WIDTH-1:0] = `DP_CAUSE_CODE;
  end

  // --------------------------------------------------------------
  // Data-protection pulse
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      DP_HOST_OUT <= 1'b0;
    end else if (CE_IN) begin
      DP_HOST_OUT <= rt.dp_host;
    end
  end

  // --------------------------------------------------------------
  // System error taken in host
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      SE_HOST_OUT <= 1'b0;
    end else if (CE_IN) begin
      SE_HOST_OUT <= (rt.se_route == fault_route_pkg::ROUTE_HOST);
    end
  end

  // --------------------------------------------------------------
  // System error kept in guest
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      SE_GUEST_OUT <= 1'b0;
    end else if (CE_IN) begin
      SE_GUEST_OUT <= (rt.se_route == fault_route_pkg::ROUTE_GUEST);
    end
  end

  // --------------------------------------------------------------
  // Saved guest flag
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      GUEST_MODE_FLAG_OUT <= 1'b0;
    end else if (CE_IN && rt.dp_host) begin
      GUEST_MODE_FLAG_OUT <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Fault cause
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CAUSE_OUT <= CAUSE_W'(`CAUSE_RST_VALUE);
    end else if (CE_IN && rt.dp_host) begin
      CAUSE_OUT <= cause_next;
    end
  end

  // --------------------------------------------------------------
  // Violation address
  // --------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      VIOL_ADDR_OUT <= ADDR_W'(`ADDR_RST_VALUE);
    end else if (CE_IN && rt.dp_host) begin
      VIOL_ADDR_OUT <= TBL_ADDR_IN;
    end
  end

  // --------------------------------------------------------------
  // Routing checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  chk_host_table_irq: assert property (
    CE_IN && GUEST_MODE_IN && TBL_FAULT_IN && !TBL_GUEST_IRQ_IN
    |=> DP_HOST_OUT)
    else $error("table fault not taken in host");
  chk_guest_table_irq: assert property (
    CE_IN && GUEST_MODE_IN && TBL_FAULT_IN && TBL_GUEST_IRQ_IN
    |=> DP_HOST_OUT == ($past(TBL_HOST_ENTRY_IN) &&
    $past(host_entry_check_enable)))
    else $error("guest table fault misrouted");
  chk_no_fault_quiet: assert property (
    CE_IN && !TBL_FAULT_IN |=> !DP_HOST_OUT)
    else $error("host pulse without table fault");
  chk_se_host: assert property (
    CE_IN && SE_IN && GUEST_MODE_IN && se_kind_routed(SE_KIND_IN) &&
    sys_error_to_host |=> SE_HOST_OUT && !SE_GUEST_OUT)
    else $error("system error not taken in host");
  chk_se_guest: assert property (
    CE_IN && SE_IN && GUEST_MODE_IN && se_kind_routed(SE_KIND_IN) &&
    !sys_error_to_host |=> SE_GUEST_OUT && !SE_HOST_OUT)
    else $error("system error left guest");
  chk_other_kind_quiet: assert property (
    CE_IN && !se_kind_routed(SE_KIND_IN)
    |=> !SE_HOST_OUT && !SE_GUEST_OUT)
    else $error("unlisted system error routed");
  chk_se_quiet: assert property (
    CE_IN && !SE_IN |=> !SE_HOST_OUT && !SE_GUEST_OUT)
    else $error("system error pulse without error");
  chk_host_mode_quiet: assert property (
    CE_IN && !GUEST_MODE_IN |=>
    !DP_HOST_OUT && !SE_HOST_OUT && !SE_GUEST_OUT)
    else $error("routing outside guest mode");

  // --------------------------------------------------------------
  // Recording checks
  // --------------------------------------------------------------
  chk_cause_code: assert property (
    DP_HOST_OUT |-> GUEST_MODE_FLAG_OUT &&
    CAUSE_OUT[`CAUSE_LOW_WIDTH-1:0] == `DP_CAUSE_CODE)
    else $error("cause not recorded");
  chk_flag_sticky: assert property (
    GUEST_MODE_FLAG_OUT |=> GUEST_MODE_FLAG_OUT)
    else $error("saved guest flag dropped");
  chk_viol_addr: assert property (
    CE_IN && rt.dp_host |=> VIOL_ADDR_OUT == $past(TBL_ADDR_IN))
    else $error("address not stored");
  chk_viol_hold: assert property (
    CE_IN && !rt.dp_host |=> $stable(VIOL_ADDR_OUT))
    else $error("address changed without fault");
  chk_freeze_hold: assert property (
    !CE_IN |=> $stable(CAUSE_OUT) && $stable(VIOL_ADDR_OUT) &&
    $stable(GUEST_MODE_FLAG_OUT) && $stable(DP_HOST_OUT))
    else $error("state moved while frozen");

  // --------------------------------------------------------------
  // Coverage
  // --------------------------------------------------------------
  cov_host_irq: cover property (DP_HOST_OUT && !$past(TBL_GUEST_IRQ_IN));
  cov_guest_irq: cover property (DP_HOST_OUT && $past(TBL_GUEST_IRQ_IN));
  cov_check_off: cover property (CE_IN && GUEST_MODE_IN && TBL_FAULT_IN &&
    TBL_GUEST_IRQ_IN && !host_entry_check_enable);
  cov_se_host: cover property (SE_HOST_OUT);
  cov_se_guest: cover property (SE_GUEST_OUT);
endmodule : guest_fault_routing
`default_nettype wire

// *** sim/guest_fault_routing_bench.sv ***
// Self-checking bench for the guest fault router.
`include "fault_route_map.svh"
`timescale 1ns/10ps
`default_nettype none
module guest_fault_routing_bench;
  logic CLK_IN, RSTN_IN, CE_IN, GUEST_MODE_IN, TBL_FAULT_IN, SE_IN;
  logic TBL_GUEST_IRQ_IN, TBL_HOST_ENTRY_IN;
  logic [1:0] GUEST_CONFIG_IN, SE_KIND_IN;
  logic [31:0] TBL_ADDR_IN, CAUSE_OUT, VIOL_ADDR_OUT;
  logic DP_HOST_OUT, SE_HOST_OUT, SE_GUEST_OUT, GUEST_MODE_FLAG_OUT;
  int miscompares = 0;
  int tests_run = 0;
  guest_fault_routing u_dut (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
    .CE_IN(CE_IN), .GUEST_MODE_IN(GUEST_MODE_IN),
    .GUEST_CONFIG_IN(GUEST_CONFIG_IN), .TBL_FAULT_IN(TBL_FAULT_IN),
    .TBL_GUEST_IRQ_IN(TBL_GUEST_IRQ_IN), .TBL_ADDR_IN(TBL_ADDR_IN),
    .TBL_HOST_ENTRY_IN(TBL_HOST_ENTRY_IN), .SE_IN(SE_IN),
    .SE_KIND_IN(SE_KIND_IN), .DP_HOST_OUT(DP_HOST_OUT),
    .SE_HOST_OUT(SE_HOST_OUT), .SE_GUEST_OUT(SE_GUEST_OUT),
    .GUEST_MODE_FLAG_OUT(GUEST_MODE_FLAG_OUT), .CAUSE_OUT(CAUSE_OUT),
    .VIOL_ADDR_OUT(VIOL_ADDR_OUT));
  initial begin
    CLK_IN = 1'b0;
    forever #12.5 CLK_IN = ~CLK_IN;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One request cycle; returns just after the edge that shows the answer.
  task automatic fire(input logic tf, gi, he, se, input logic [1:0] k, cfg,
                      input logic [31:0] a);
    @(posedge CLK_IN);
    #1;
    TBL_FAULT_IN = tf;
    TBL_GUEST_IRQ_IN = gi;
    TBL_HOST_ENTRY_IN = he;
    SE_IN = se;
    SE_KIND_IN = k;
    GUEST_CONFIG_IN = cfg;
    TBL_ADDR_IN = a;
    @(posedge CLK_IN);
    #1;
    TBL_FAULT_IN = 1'b0;
    SE_IN = 1'b0;
  endtask : fire
  task automatic t_refused;
    GUEST_MODE_IN = 1'b0;
    fire(1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 2'h3, 32'h0000_0100);
    chk("dp_host", DP_HOST_OUT, 1'b0);
    chk("se_host", SE_HOST_OUT, 1'b0);
    chk("flag", GUEST_MODE_FLAG_OUT, 1'b0);
    chk("se_guest", SE_GUEST_OUT, 1'b0);
    chk("viol_addr", VIOL_ADDR_OUT, `ADDR_RST_VALUE);
    GUEST_MODE_IN = 1'b1;
    CE_IN = 1'b0;
    fire(1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 2'h3, 32'h0000_0100);
    chk("dp_host", DP_HOST_OUT, 1'b0);
    chk("se_host", SE_HOST_OUT, 1'b0);
    chk("se_guest", SE_GUEST_OUT, 1'b0);
    chk("viol_addr", VIOL_ADDR_OUT, `ADDR_RST_VALUE);
    CE_IN = 1'b1;
    $display("test refused done");
  endtask : t_refused
  task automatic t_table(input logic gi, input logic [31:0] a);
    fire(1'b1, gi, gi, 1'b0, 2'h0, {1'b0, gi}, a);
    chk("dp_host", DP_HOST_OUT, 1'b1);
    chk("flag", GUEST_MODE_FLAG_OUT, 1'b1);
    chk("cause", CAUSE_OUT[15:0], `DP_CAUSE_CODE);
    chk("cause_high", CAUSE_OUT[31:16], 16'h0000);
    chk("viol_addr", VIOL_ADDR_OUT, a);
    @(posedge CLK_IN);
    #1;
    chk("dp_host", DP_HOST_OUT, 1'b0);
    $display("test table fault done");
  endtask : t_table
  task automatic t_check_off(input logic [31:0] prev);
    fire(1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 32'h0000_0200);
    chk("dp_host", DP_HOST_OUT, 1'b0);
    chk("viol_addr", VIOL_ADDR_OUT, prev);
    fire(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 32'h0000_0300);
    chk("dp_host", DP_HOST_OUT, 1'b0);
    chk("viol_addr", VIOL_ADDR_OUT, prev);
    $display("test guest check off done");
  endtask : t_check_off
  task automatic t_reset;
    @(posedge CLK_IN);
    #1;
    RSTN_IN = 1'b0;
    repeat (2) @(posedge CLK_IN);
    #1;
    chk("dp_host", DP_HOST_OUT, 1'b0);
    chk("flag", GUEST_MODE_FLAG_OUT, 1'b0);
    chk("cause", CAUSE_OUT, `CAUSE_RST_VALUE);
    chk("viol_addr", VIOL_ADDR_OUT, `ADDR_RST_VALUE);
    RSTN_IN = 1'b1;
    fire(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 32'h0000_0a5c);
    chk("dp_host", DP_HOST_OUT, 1'b1);
    chk("flag", GUEST_MODE_FLAG_OUT, 1'b1);
    chk("viol_addr", VIOL_ADDR_OUT, 32'h0000_0a5c);
    $display("test reset done");
  endtask : t_reset
  task automatic t_syserr;
    logic h;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 2; b++) begin
        h = (b == 1);
        fire(1'b0, 1'b0, 1'b0, 1'b1, 2'(k), {h, 1'b0}, 32'h0);
        chk("se_host", SE_HOST_OUT, (k != 3) && h);
        chk("se_guest", SE_GUEST_OUT, (k != 3) && !h);
      end
    end
    $display("test system error done");
  endtask : t_syserr
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    {RSTN_IN, CE_IN, GUEST_MODE_IN, TBL_FAULT_IN, SE_IN} = 5'h0c;
    {TBL_GUEST_IRQ_IN, TBL_HOST_ENTRY_IN} = 2'h0;
    {GUEST_CONFIG_IN, SE_KIND_IN, TBL_ADDR_IN} = 36'h0;
    repeat (4) @(posedge CLK_IN);
    #1;
    RSTN_IN = 1'b1;
    t_refused();
    t_table(1'b0, 32'h1234_5678);
    t_table(1'b1, 32'hfedc_0a40);
    t_check_off(32'hfedc_0a40);
    t_reset();
    t_syserr();
    summarize();
  end
endmodule : guest_fault_routing_bench
`default_nettype wire
